// *** include/tto_pkg.sv ***
// package for the timer toggle output block: register map, field positions, reset values
// assumes an 8-bit special-function register port shared with the core
package tto_pkg;
  localparam logic [7:0]  TTO_ADDR_CONTROL  = 8'hc8;
  localparam logic [7:0]  TTO_ADDR_CONFIG   = 8'hc9;
  localparam logic [7:0]  TTO_ADDR_RELOAD_L = 8'hca;
  localparam logic [7:0]  TTO_ADDR_RELOAD_H = 8'hcb;
  localparam logic [7:0]  TTO_ADDR_COUNT_L  = 8'hcc;
  localparam logic [7:0]  TTO_ADDR_COUNT_H  = 8'hcd;
  // control register fields
  localparam int          TTO_CN_OVF        = 7;
  localparam int          TTO_CN_EXF        = 6;
  localparam int          TTO_CN_EXEN       = 3;
  localparam int          TTO_CN_RUN        = 2;
  localparam int          TTO_CN_CT         = 1;
  localparam int          TTO_CN_CPRL       = 0;
  // configuration register fields
  localparam int          TTO_CF_TOG        = 2;
  localparam int          TTO_CF_OE         = 1;
  localparam int          TTO_CF_COUNT_DOWN_ENABLE       = 0;
  localparam logic [7:0]  TTO_CN_RESET      = 8'h00;
  localparam logic [7:0]  TTO_CF_RESET      = 8'h00;
  localparam logic [7:0]  TTO_CN_WMASK      = 8'hcf;
  localparam logic [7:0]  TTO_CF_WMASK      = 8'h1f;
  localparam logic [15:0] TTO_COUNT_MAX     = 16'hffff;
  localparam logic [15:0] TTO_ZERO16        = 16'h0000;
  localparam logic [7:0]  TTO_ZERO8         = 8'h00;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tto_sfr_req_t;

  typedef struct packed {
    logic       ovf;
    logic       up;
    logic       reload;
  } tto_event_t;
endpackage

// *** src/tto_counter.sv ***
// 16-bit up/down counter core with overflow/underflow detection and reload
// assumes the caller supplies a one-cycle tick per timer clock and the reload value
module tto_counter
  import tto_pkg::*;
(
  input  wire logic              clk_sys,    // system clock
  input  wire logic              nrst,       // synchronous reset, active low
  input  wire logic              tick,       // one count event
  input  wire logic              countUp,    // direction
  input  wire logic [15:0]       reloadVal,  // reload/capture value
  input  wire logic              loadEn,     // software write to count
  input  wire logic [15:0]       loadVal,    // value written
  input  wire logic              extReload,  // reload request from the external pin
  output logic [15:0]            count,      // current count
  output tto_pkg::tto_event_t    evt         // overflow/underflow pulse
);
  import tto_pkg::*;

  logic [15:0] count_q, count_d;
  tto_event_t  evt_d;

  always_comb begin
    count_d     = count_q;
    evt_d       = '0;
    evt_d.up    = countUp;
    if (loadEn) begin
      count_d = loadVal;
    end else if (extReload) begin
      count_d      = countUp ? reloadVal : TTO_COUNT_MAX;
      evt_d.reload = 1'b1;
    end else if (tick) begin
      if (countUp) begin
        if (count_q == TTO_COUNT_MAX) begin
          count_d   = reloadVal;
          evt_d.ovf = 1'b1;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end else begin
        if (count_q == reloadVal) begin
          count_d   = TTO_COUNT_MAX;
          evt_d.ovf = 1'b1;
        end else begin
          count_d = count_q - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      count_q <= TTO_ZERO16;
    end else begin
      count_q <= count_d;
    end
  end

  assign count = count_q;
  assign evt   = evt_d;
endmodule

// *** src/tto_timer_toggle.sv ***
// What this block does
// - toggle output inverts on every overflow or underflow, 50% duty wave
// - counting down, underflow when count equals reload value, then load 0xffff
// - counting up, overflow on wrap past maximum, then load reload value
// - toggle level reaches the pin only while output enable is one
// - writing run bit one starts counting and toggling
// - toggle state bit reads the output level; writing it forces the level
// - half period is 65536 minus reload value, counting up or down
// - with decrement enable in auto-reload, direction pin sets direction
// - each overflow or underflow sets flag bit 7 and requests interrupt
// - in auto-reload external flag inverts on every event, no interrupt
// - direction enabled in auto-reload: pin high counts up, pin low counts down
//
// timer with toggle output; registers on an 8-bit special-function register port
// assumes all inputs synchronous to clk_sys; timer clock is a one-cycle tick input
module tto_timer_toggle
  import tto_pkg::*;
(
  input  wire logic                 clk_sys,        // system clock 200 MHz
  input  wire logic                 nrst,           // synchronous reset, active low
  input  wire tto_pkg::tto_sfr_req_t sfrReq,        // register access request
  output logic [7:0]                sfrRdData,      // read data, registered
  input  wire logic                 timerTick,      // selected timer clock event
  input  wire logic                 dirTrigPin,     // direction/trigger pin level
  output logic                      toggleOutPin,   // toggle output level
  output logic                      toggleOutOe,    // pin driven while high
  output logic                      irqReq          // overflow interrupt request
);
  import tto_pkg::*;

  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  cfg_q, cfg_d;
  logic [15:0] reload_q, reload_d;
  logic        tog_q, tog_d;
  logic        dirPin_q, dirPin_d;
  logic [7:0]  rd_q, rd_d;
  logic        oe_q, oe_d;
  logic        pin_q, pin_d;
  logic        irq_q, irq_d;

  logic [15:0] count;
  tto_event_t  evt;
  logic        running;
  logic        countUp;
  logic        extReload;
  logic        cntLoad;
  logic [15:0] cntLoadVal;

  function automatic logic hit(input tto_sfr_req_t r, input logic [7:0] a);
    return r.wrEn && (r.addr == a);
  endfunction

  assign running = ctrl_q[TTO_CN_RUN];
  // direction from the pin only in auto-reload with decrement enable
  assign countUp = !(cfg_q[TTO_CF_COUNT_DOWN_ENABLE] && !ctrl_q[TTO_CN_CPRL]) || dirTrigPin;
  // falling edge of the pin reloads only when it is not steering direction
  assign extReload = running && ctrl_q[TTO_CN_EXEN] && !cfg_q[TTO_CF_COUNT_DOWN_ENABLE]
                     && !ctrl_q[TTO_CN_CPRL] && dirPin_q && !dirTrigPin;
  assign cntLoad    = hit(sfrReq, TTO_ADDR_COUNT_L) || hit(sfrReq, TTO_ADDR_COUNT_H);
  assign cntLoadVal = hit(sfrReq, TTO_ADDR_COUNT_L) ? {count[15:8], sfrReq.wrData}
                                                    : {sfrReq.wrData, count[7:0]};

  tto_counter u_counter (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .tick      (timerTick && running),
    .countUp   (countUp),
    .reloadVal (reload_q),
    .loadEn    (cntLoad),
    .loadVal   (cntLoadVal),
    .extReload (extReload),
    .count     (count),
    .evt       (evt)
  );

  // register file; hardware set wins over a software clear in the same cycle
  always_comb begin
    ctrl_d   = ctrl_q;
    cfg_d    = cfg_q;
    reload_d = reload_q;
    tog_d    = tog_q;
    dirPin_d = dirTrigPin;
    if (hit(sfrReq, TTO_ADDR_CONTROL)) begin
      ctrl_d = sfrReq.wrData & TTO_CN_WMASK;
    end
    if (hit(sfrReq, TTO_ADDR_CONFIG)) begin
      cfg_d = sfrReq.wrData & TTO_CF_WMASK;
      tog_d = sfrReq.wrData[TTO_CF_TOG];
    end
    if (hit(sfrReq, TTO_ADDR_RELOAD_L)) begin
      reload_d[7:0] = sfrReq.wrData;
    end
    if (hit(sfrReq, TTO_ADDR_RELOAD_H)) begin
      reload_d[15:8] = sfrReq.wrData;
    end
    if (evt.ovf) begin
      ctrl_d[TTO_CN_OVF] = 1'b1;
      tog_d              = !tog_d;
      if (!ctrl_q[TTO_CN_CPRL]) begin
        ctrl_d[TTO_CN_EXF] = !ctrl_d[TTO_CN_EXF];
      end
    end
    if (evt.reload) begin
      ctrl_d[TTO_CN_EXF] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      ctrl_q   <= TTO_CN_RESET;
      cfg_q    <= TTO_CF_RESET;
      reload_q <= TTO_ZERO16;
      tog_q    <= 1'b0;
      dirPin_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      cfg_q    <= cfg_d;
      reload_q <= reload_d;
      tog_q    <= tog_d;
      dirPin_q <= dirPin_d;
    end
  end

  // outputs, all from flops; the external flag feeds irq only in capture mode, so the pin edge flag of auto-reload does not
  always_comb begin
    rd_d = TTO_ZERO8;
    if (sfrReq.rdEn) begin
      unique case (sfrReq.addr)
        TTO_ADDR_CONTROL:  rd_d = ctrl_q;
        TTO_ADDR_CONFIG:   rd_d = {cfg_q[7:3], tog_q, cfg_q[1:0]};
        TTO_ADDR_RELOAD_L: rd_d = reload_q[7:0];
        TTO_ADDR_RELOAD_H: rd_d = reload_q[15:8];
        TTO_ADDR_COUNT_L:  rd_d = count[7:0];
        TTO_ADDR_COUNT_H:  rd_d = count[15:8];
        default:           rd_d = TTO_ZERO8;
      endcase
    end
    oe_d  = cfg_d[TTO_CF_OE];
    pin_d = tog_d;
    // overflow flag always requests; external flag only in capture mode
    irq_d = ctrl_d[TTO_CN_OVF] || (ctrl_d[TTO_CN_EXF] && ctrl_d[TTO_CN_CPRL]);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_q  <= TTO_ZERO8;
      oe_q  <= 1'b0;
      pin_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      rd_q  <= rd_d;
      oe_q  <= oe_d;
      pin_q <= pin_d;
      irq_q <= irq_d;
    end
  end

  assign sfrRdData    = rd_q;
  assign toggleOutOe  = oe_q;
  assign toggleOutPin = pin_q;
  assign irqReq       = irq_q;
endmodule

// *** verif/testbench.sv ***
// random bench for the toggle timer: reloads, directions, forced levels
// assumes tto_pkg and the checker compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tto_pkg::*;
  logic         clk_sys = 1'b0;
  logic         nrst = 1'b0;
  tto_sfr_req_t sfrReq = '0;
  logic [7:0]   sfrRdData;
  logic         timerTick = 1'b0, dirTrigPin = 1'b0, tickOn = 1'b0, lastPin = 1'b0;
  logic         toggleOutPin, toggleOutOe, irqReq;
  int           error_cnt = 0, samples_checked = 0, seed = 32'hba77;
  int           ticks = 0, halfLen = 0, flips = 0;
  tto_timer_toggle tto_timer_toggle_i (.clk_sys(clk_sys), .nrst(nrst), .sfrReq(sfrReq),
    .sfrRdData(sfrRdData), .timerTick(timerTick), .dirTrigPin(dirTrigPin),
    .toggleOutPin(toggleOutPin), .toggleOutOe(toggleOutOe), .irqReq(irqReq));
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) timerTick <= tickOn && ($random(seed) % 2) != 0;
  // ticks are counted per toggle; the causing tick lands one edge before the pin moves
  always @(posedge clk_sys) begin
    if (toggleOutPin !== lastPin) begin
      halfLen <= ticks;
      ticks <= int'(timerTick);
      flips <= flips + 1;
    end else ticks <= ticks + int'(timerTick);
    lastPin <= toggleOutPin;
  end
  function automatic logic [15:0] half_exp(logic [15:0] r);
    return 16'(17'h10000 - r);
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    sfrReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk_sys);
    sfrReq <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    sfrReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk_sys);
    sfrReq <= '0;
    #1 d = sfrRdData;
  endtask
  task automatic wait_flips(int n);
    // three half periods of up to 64 ticks each at a random tick rate of one half
    for (int i = 0; i < 2000 && flips < n; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (flips < n) begin
      error_cnt++;
      give_verdict();
    end
  endtask
  initial begin
    logic [7:0]  d, cfg;
    logic [15:0] r;
    logic        up, pin;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(TTO_ADDR_CONTROL, d);
    check("control reset", d, TTO_CN_RESET);
    rd(TTO_ADDR_CONFIG, d);
    check("config reset", d, TTO_CF_RESET);
    rd(8'h00, d);
    check("unmapped read", d, 8'h00);
    for (int k = 0; k < 8; k++) begin
      r = (k == 0) ? 16'hffff : 16'hffff - 16'($random(seed) & 63);
      cfg = 8'($random(seed)) & 8'h07;
      pin = ($random(seed) % 2) != 0;
      up = !cfg[TTO_CF_COUNT_DOWN_ENABLE] || pin;
      @(posedge clk_sys);
      dirTrigPin <= pin;
      wr(TTO_ADDR_RELOAD_L, r[7:0]);
      wr(TTO_ADDR_RELOAD_H, r[15:8]);
      wr(TTO_ADDR_COUNT_L, up ? r[7:0] : 8'hff);
      wr(TTO_ADDR_COUNT_H, up ? r[15:8] : 8'hff);
      wr(TTO_ADDR_CONFIG, cfg);
      rd(TTO_ADDR_CONFIG, d);
      check("forced level", d[TTO_CF_TOG], cfg[TTO_CF_TOG]);
      check("output enable", toggleOutOe, cfg[TTO_CF_OE]);
      flips = 0;
      wr(TTO_ADDR_CONTROL, 8'h04);
      tickOn = 1'b1;
      wait_flips(3);
      check("half period", 16'(halfLen), half_exp(r));
      tickOn = 1'b0;
      rd(TTO_ADDR_CONTROL, d);
      check("flags", d & 8'hc4, {1'b1, flips[0], 6'h04});
      wr(TTO_ADDR_CONTROL, 8'h00);
      flips = 0;
      tickOn = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1 tickOn = 1'b0;
      check("stopped", 16'(flips), 16'h0000);
    end
    give_verdict();
  end
endmodule
bind tto_timer_toggle tto_timer_toggle_asserts tto_timer_toggle_asserts_i (.clk_sys(clk_sys),
  .nrst(nrst), .sfrReq(sfrReq), .sfrRdData(sfrRdData), .timerTick(timerTick),
  .dirTrigPin(dirTrigPin), .toggleOutPin(toggleOutPin), .toggleOutOe(toggleOutOe),
  .irqReq(irqReq));

// *** verif/tto_timer_toggle_asserts.sv ***
// port assertions for the toggle timer
// assumes binding onto tto_timer_toggle, one clock domain
module tto_timer_toggle_asserts
  import tto_pkg::*;
(
  input wire logic                  clk_sys,      // clock
  input wire logic                  nrst,         // reset, active low
  input wire tto_pkg::tto_sfr_req_t sfrReq,       // register request
  input wire logic [7:0]            sfrRdData,    // read data
  input wire logic                  timerTick,    // count event
  input wire logic                  dirTrigPin,   // direction pin
  input wire logic                  toggleOutPin, // toggle level
  input wire logic                  toggleOutOe,  // output enable
  input wire logic                  irqReq        // interrupt
);
  import tto_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic cfgWr, ctlWr, capD, capQ;
  assign cfgWr = sfrReq.wrEn && sfrReq.addr == TTO_ADDR_CONFIG;
  assign ctlWr = sfrReq.wrEn && sfrReq.addr == TTO_ADDR_CONTROL;
  // capture mode lets the external flag reach the interrupt
  always_comb capD = !nrst ? 1'b0 : ctlWr ? sfrReq.wrData[TTO_CN_CPRL] : capQ;
  always_ff @(posedge clk_sys) capQ <= capD;
  sequence hwToggle;
    $changed(toggleOutPin) && !$past(cfgWr);
  endsequence
  reset_outputs_a: assert property (!$past(nrst) |-> !toggleOutPin && !toggleOutOe && !irqReq)
    else $error("outputs not clear after reset");
  oe_follows_a: assert property (cfgWr |=> toggleOutOe == $past(sfrReq.wrData[TTO_CF_OE]))
    else $error("output enable not taken");
  force_level_a: assert property (cfgWr && !timerTick |=> toggleOutPin == $past(sfrReq.wrData[TTO_CF_TOG]))
    else $error("forced level not applied");
  toggle_cause_a: assert property ($changed(toggleOutPin) |-> $past(timerTick) || $past(cfgWr))
    else $error("toggle without cause");
  irq_on_event_a: assert property (hwToggle |-> irqReq)
    else $error("event without flag");
  irq_cause_a: assert property ($rose(irqReq) && !capQ |-> $past(timerTick) || $past(ctlWr))
    else $error("interrupt without event");
  irq_clear_a: assert property (ctlWr && !sfrReq.wrData[TTO_CN_OVF] && !sfrReq.wrData[TTO_CN_CPRL]
    && !timerTick |=> !irqReq)
    else $error("flag not cleared");
  ctl_rsvd_a: assert property (sfrReq.rdEn && sfrReq.addr == TTO_ADDR_CONTROL |=> sfrRdData[5:4] == 2'b00)
    else $error("reserved bits not zero");
endmodule
